// file: verilog/rmp_pkg.sv
// Behaviour
// R01 - Every button and switch except emergency stop is readable by the console; REG_INPUTS also returns the stop button
// R02 - Middle region lamp lit when core is in neither region one nor three
// R03 - Region move switch backlights follow their door limit switch inputs
// R04 - Lead door open, stop, close light their backlight and command the door
// R05 - Operate lamp lit only with interlocks satisfied and magnet power allowed
// R06 - Time delay lamp lit while the 30 second interlock delay runs
// R07 - Steady state: fission chamber on pulsing channel, both detector lamps off
// R08 - First detector press selects detector 1, next press selects detector 2
// R09 - Lamp test lights every panel lamp; its own button has no lamp
// R10 - Emergency stop drops the permissive relay without any software
// R11 - Emergency stop latches: one press sets, the next press clears
// R12 - Instrument power backlight lit whenever console power is on
// R13 - Instrument power press toggles the supply 2 to 3 seconds later
// R14 - Console and terminal watchdog lamps light on their timeouts
// R15 - Each selector picks a test; its button simulates the trip conditions
// R16 - Both selectors act independently and may be active together
// R17 - Selector one: log, multirange, linear, pulsing channel trip sets
// R18 - Multirange test scrams bypassed but a warning is still raised
// R19 - Selector two: watchdogs, pool level, fuel temperatures, pool temp
// R20 - Key reset starts the interlock delay before the relay energises
// R21 - Buttons synchronised and debounced, one press gives one event
package rmp_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint unsigned CLK_HZ   = 200_000_000;
    localparam longint unsigned DEB_MS   = 10;
    localparam longint unsigned DELAY_S  = 30;
    localparam longint unsigned UPS_MS   = 2000;
    localparam int              DEB_W    = 21;
    localparam int              DLY_W    = 33;
    localparam int              UPS_W    = 29;
    localparam logic [DEB_W-1:0] DEB_CYC =
        DEB_W'(CLK_HZ / 1000 * DEB_MS);
    localparam logic [DLY_W-1:0] DLY_CYC =
        DLY_W'(CLK_HZ * DELAY_S);
    localparam logic [UPS_W-1:0] UPS_CYC =
        UPS_W'(CLK_HZ / 1000 * UPS_MS);

    // ****************************************
    // Register map
    // ****************************************
    localparam int         ADDR_W     = 4;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_INPUTS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_TRIPS  = 4'hC;
    localparam int         CTRL_ILK   = 0;
    localparam int         CTRL_WDC   = 1;
    localparam int         CTRL_WDT   = 2;
    localparam logic [2:0] CTRL_RST   = 3'h0;

    // ****************************************
    // Buttons, selector positions
    // ****************************************
    localparam int NBTN  = 12;
    localparam int B_DET = 11;
    localparam int B_EST = 10;
    localparam int B_PWR = 9;
    localparam int B_T1  = 8;
    localparam int B_T2  = 7;
    localparam int B_KEY = 6;
    localparam int B_LT  = 0;
    localparam logic [1:0] T1_LOG = 2'h0;
    localparam logic [1:0] T1_MR  = 2'h1;
    localparam logic [1:0] T1_LIN = 2'h2;
    localparam logic [1:0] T1_PUL = 2'h3;
    localparam logic [1:0] T2_WDT = 2'h0;
    localparam logic [1:0] T2_LVL = 2'h1;
    localparam logic [1:0] T2_FT  = 2'h2;
    localparam logic [1:0] T2_PT  = 2'h3;

    typedef enum logic [1:0] {DET_NONE, DET_ONE, DET_TWO} rmp_det_e;
    typedef enum logic [1:0] {PERM_OFF, PERM_DELAY, PERM_ON} rmp_perm_e;

    typedef struct packed {
        logic det_sel;
        logic estop;
        logic instr_pwr;
        logic test1;
        logic test2;
        logic key_reset;
        logic region1;
        logic region3;
        logic door_open;
        logic door_stop;
        logic door_close;
        logic lamp_test;
    } rmp_btn_s;

    typedef struct packed {
        logic       core_r1;
        logic       core_r3;
        logic       lim_r1;
        logic       lim_r3;
        logic       console_pwr;
        logic       exp_room_open;
        logic [1:0] sel1;
        logic [1:0] sel2;
    } rmp_sense_s;

    typedef struct packed {
        logic region1;
        logic region2;
        logic region3;
        logic door_open;
        logic door_stop;
        logic door_close;
        logic operate;
        logic time_delay;
        logic exp_room;
        logic det1;
        logic det2;
        logic estop;
        logic instr_pwr;
        logic wdt_console;
        logic wdt_terminal;
    } rmp_lamps_s;

    typedef struct packed {
        logic log_1kw;
        logic log_low_src;
        logic log_period;
        logic log_hv_lo;
        logic mr_hv_lo;
        logic mr_pwr_hi;
        logic lin_hv_lo;
        logic lin_pwr_hi;
        logic pul_hv_lo;
        logic pul_pwr_hi;
        logic wdt_console;
        logic wdt_terminal;
        logic pool_lo;
        logic ft1;
        logic ft2;
        logic ft3;
        logic pool_temp;
    } rmp_trips_s;

    typedef struct packed {
        logic [NBTN-1:0]  sync1;
        logic [NBTN-1:0]  sync2;
        logic [NBTN-1:0]  samp;
        logic [NBTN-1:0]  stab;
        logic [DEB_W-1:0] deb_cnt;
        rmp_sense_s       sense;
        rmp_det_e         det;
        logic             estop;
        rmp_perm_e        perm;
        logic [DLY_W-1:0] dly_cnt;
        logic             relay;
        logic             ups_on;
        logic             ups_pend;
        logic [UPS_W-1:0] ups_cnt;
        logic [2:0]       ctrl;
        logic [2:0]       door;
        rmp_lamps_s       lamps;
        rmp_trips_s       trips;
        logic             warn;
        logic [31:0]      rdata;
    } rmp_state_s;

    localparam rmp_state_s ST_RST = '0;

endpackage : rmp_pkg

// file: verilog/rmp_panel.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rmp_panel #(
    parameter logic [rmp_pkg::DEB_W-1:0] DEB_CYC = rmp_pkg::DEB_CYC,
    parameter logic [rmp_pkg::DLY_W-1:0] DLY_CYC = rmp_pkg::DLY_CYC,
    parameter logic [rmp_pkg::UPS_W-1:0] UPS_CYC = rmp_pkg::UPS_CYC
) (
    input  wire logic                       clock_i,
    input  wire logic                       sys_rst_i,
    input  wire rmp_pkg::rmp_btn_s          btn_i,
    input  wire rmp_pkg::rmp_sense_s        sense_i,
    input  wire logic [rmp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic [31:0]                     rdata_o,
    output rmp_pkg::rmp_lamps_s             lamps_o,
    output rmp_pkg::rmp_trips_s             trips_o,
    output logic                            warning_o,
    output logic                            relay_o,
    output logic                            ups_on_o,
    output logic [2:0]                      door_cmd_o,
    output rmp_pkg::rmp_det_e               det_o
);
    import rmp_pkg::*;

    rmp_state_s      s;
    rmp_state_s      n;
    logic [NBTN-1:0] press;
    logic            tick;
    logic            core_mid;
    logic [16:0]     both_map;

    // ****************************************
    // Test selector decode
    // ****************************************
    function automatic rmp_trips_s trip_map(
        input logic       run1,
        input logic       run2,
        input logic [1:0] sel1,
        input logic [1:0] sel2
    );
        rmp_trips_s t;
        t = '0;
        if (run1) begin // R15
            case (sel1) // R17
                T1_LOG: begin
                    t.log_1kw     = 1'b1;
                    t.log_low_src = 1'b1;
                    t.log_period  = 1'b1;
                    t.log_hv_lo   = 1'b1;
                end
                T1_MR: begin // R18
                    t.mr_hv_lo  = 1'b1;
                    t.mr_pwr_hi = 1'b1;
                end
                T1_LIN: begin
                    t.lin_hv_lo  = 1'b1;
                    t.lin_pwr_hi = 1'b1;
                end
                default: begin
                    t.pul_hv_lo  = 1'b1;
                    t.pul_pwr_hi = 1'b1;
                end
            endcase
        end
        if (run2) begin // R15
            case (sel2) // R19
                T2_WDT: begin
                    t.wdt_console  = 1'b1;
                    t.wdt_terminal = 1'b1;
                end
                T2_LVL: begin
                    t.pool_lo = 1'b1;
                end
                T2_FT: begin
                    t.ft1 = 1'b1;
                    t.ft2 = 1'b1;
                    t.ft3 = 1'b1;
                end
                default: begin
                    t.pool_temp = 1'b1;
                end
            endcase
        end
        return t;
    endfunction : trip_map

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = s;
        // Raw pins only feed the first stage; the filter sees stage two
        n.sync1 = btn_i; // R21
        n.sync2 = s.sync1;
        n.sense = sense_i;

        // A shared sampling tick keeps one counter for all buttons; a press
        // must hold over two ticks, so bounce shorter than a tick is lost
        tick = (s.deb_cnt == DEB_CYC - 1'b1);
        n.deb_cnt = tick ? '0 : s.deb_cnt + 1'b1;
        if (tick) begin // R21
            n.samp = s.sync2;
            if (s.samp == s.sync2) begin
                n.stab = s.sync2;
            end
        end
        press = n.stab & ~s.stab; // R21

        // Detector selection, none means the fission chamber stays on
        if (press[B_DET]) begin // R08
            case (s.det)
                DET_NONE: n.det = DET_ONE;
                DET_ONE:  n.det = DET_TWO;
                default:  n.det = DET_NONE; // R07
            endcase
        end

        if (press[B_EST]) begin // R11
            n.estop = ~s.estop;
        end

        // Permissive sequence
        case (s.perm)
            PERM_OFF: begin
                if (press[B_KEY] && !s.estop) begin // R20
                    n.perm    = PERM_DELAY;
                    n.dly_cnt = '0;
                end
            end
            PERM_DELAY: begin
                if (s.dly_cnt == DLY_CYC - 1'b1) begin // R20
                    n.perm = PERM_ON;
                end else begin
                    n.dly_cnt = s.dly_cnt + 1'b1;
                end
            end
            PERM_ON: begin
                // Key reset while running trips the permissive
                if (press[B_KEY]) begin
                    n.perm = PERM_OFF;
                end
            end
            default: begin
                n.perm = PERM_OFF;
            end
        endcase
        // Stop is a hardware path; no register setting can override it
        if (n.estop) begin // R10
            n.perm = PERM_OFF;
        end
        n.relay = (n.perm == PERM_ON) && !n.estop; // R10

        // Supply toggle; presses during the wait are ignored so that a
        // double press cannot leave the supply state ambiguous
        if (s.ups_pend) begin // R13
            if (s.ups_cnt == UPS_CYC - 1'b1) begin
                n.ups_pend = 1'b0;
                n.ups_on   = ~s.ups_on;
            end else begin
                n.ups_cnt = s.ups_cnt + 1'b1;
            end
        end else if (press[B_PWR]) begin
            n.ups_pend = 1'b1;
            n.ups_cnt  = '0;
        end

        n.door = {s.stab[3], s.stab[2], s.stab[1]}; // R04

        n.trips = trip_map(s.stab[B_T1], s.stab[B_T2],
                           s.sense.sel1, s.sense.sel2); // R16
        n.warn = s.stab[B_T1] && (s.sense.sel1 == T1_MR); // R18

        // ****************************************
        // Lamps
        // ****************************************
        n.lamps.region1 = s.sense.lim_r1; // R03
        n.lamps.region3 = s.sense.lim_r3; // R03
        n.lamps.region2 = !(s.sense.core_r1 || s.sense.core_r3); // R02
        n.lamps.door_open  = s.stab[3]; // R04
        n.lamps.door_stop  = s.stab[2]; // R04
        n.lamps.door_close = s.stab[1]; // R04
        n.lamps.operate = s.relay && s.ctrl[CTRL_ILK]; // R05
        n.lamps.time_delay = (s.perm == PERM_DELAY); // R06
        n.lamps.exp_room = s.sense.exp_room_open;
        n.lamps.det1 = (s.det == DET_ONE); // R08
        n.lamps.det2 = (s.det == DET_TWO); // R08
        n.lamps.estop = s.estop;
        n.lamps.instr_pwr = s.sense.console_pwr; // R12
        n.lamps.wdt_console  = s.ctrl[CTRL_WDC]; // R14
        n.lamps.wdt_terminal = s.ctrl[CTRL_WDT]; // R14
        if (s.stab[B_LT]) begin // R09
            n.lamps = '1;
        end

        // ****************************************
        // Register port
        // ****************************************
        if (wr_i && addr_i == REG_CTRL) begin
            n.ctrl = wdata_i[2:0];
        end
        n.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                REG_CTRL:   n.rdata = {29'h0, s.ctrl};
                REG_INPUTS: n.rdata = {16'h0, s.sense.sel2,
                                       s.sense.sel1, s.stab}; // R01
                REG_STATUS: n.rdata = {17'h0, s.lamps};
                REG_TRIPS:  n.rdata = {15'h0, s.trips};
                default:    n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata_o    = s.rdata;
    assign lamps_o    = s.lamps;
    assign trips_o    = s.trips;
    assign warning_o  = s.warn;
    assign relay_o    = s.relay;
    assign ups_on_o   = s.ups_on;
    assign door_cmd_o = s.door;
    assign det_o      = s.det;

    // ****************************************
    // Checks
    // ****************************************
    assign core_mid = !(s.sense.core_r1 || s.sense.core_r3);
    assign both_map = trip_map(1'b1, 1'b0, s.sense.sel1, s.sense.sel2)
                    | trip_map(1'b0, 1'b1, s.sense.sel1, s.sense.sel2);

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_first_press;
        (s.det == DET_NONE) && press[B_DET];
    endsequence

    sequence s_second_press;
        (s.det == DET_ONE) && press[B_DET];
    endsequence

    a_region_two: // R02
    assert property (!s.stab[B_LT] |=>
                     lamps_o.region2 == $past(core_mid))
        else $error("middle region lamp wrong");

    a_door_lamp: // R04
    assert property (!s.stab[B_LT] |=>
                     lamps_o.door_open == $past(s.stab[3]) &&
                     door_cmd_o[2] == $past(s.stab[3]))
        else $error("door open lamp or command wrong");

    a_operate_lamp: // R05
    assert property (lamps_o.operate && !$past(s.stab[B_LT]) |->
                     $past(s.relay) && $past(s.ctrl[CTRL_ILK]))
        else $error("operate lamp lit without permission");

    a_delay_lamp: // R06
    assert property ((s.perm == PERM_DELAY) |=> lamps_o.time_delay)
        else $error("time delay lamp dark during delay");

    a_det_first: // R08
    assert property (s_first_press |=>
                     (s.det == DET_ONE) ##1 lamps_o.det1)
        else $error("first press did not select detector one");

    a_det_second: // R08
    assert property (s_second_press |=>
                     (s.det == DET_TWO) ##1 lamps_o.det2)
        else $error("second press did not select detector two");

    a_lamp_test: // R09
    assert property (s.stab[B_LT] |=> (&lamps_o))
        else $error("lamp test left a lamp dark");

    a_estop_relay: // R10
    assert property (s.estop |-> !relay_o)
        else $error("relay held with stop active");

    a_estop_latch: // R11
    assert property (press[B_EST] |=> s.estop != $past(s.estop))
        else $error("stop press did not toggle latch");

    a_ups_change: // R13
    assert property ($changed(s.ups_on) |->
                     $past(s.ups_pend) &&
                     $past(s.ups_cnt) == UPS_CYC - 1'b1)
        else $error("supply toggled before its delay");

    a_wdt_lamp: // R14
    assert property (s.ctrl[CTRL_WDC] |=> lamps_o.wdt_console)
        else $error("watchdog lamp dark after timeout");

    a_tests_both: // R16
    assert property (s.stab[B_T1] && s.stab[B_T2] |=>
                     trips_o == $past(both_map))
        else $error("simultaneous tests not combined");

    a_mr_warning: // R18
    assert property (s.stab[B_T1] && s.sense.sel1 == T1_MR |=>
                     warning_o ##1 1'b1)
        else $error("multirange test raised no warning");

    a_press_single: // R21
    assert property (press[B_EST] |=> !press[B_EST] [*2])
        else $error("one press gave two events");

endmodule : rmp_panel

// file: bench/rmp_console_model.sv
`timescale 1ns/1ps
module rmp_console_model (
    input  wire logic                  clock_i,
    input  wire logic [31:0]           rdata_i,
    output logic [rmp_pkg::ADDR_W-1:0] addr_o,
    output logic [31:0]                wdata_o,
    output logic                       wr_o,
    output logic                       rd_o
);
    import rmp_pkg::*;

    // ****************************************
    // Console side of the register port
    // ****************************************
    initial begin
        addr_o  = '0;
        wdata_o = '0;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Idle bus shows inverted values so a stale address never looks valid
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clock_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd_reg
endmodule : rmp_console_model

// file: bench/reactor_mode_panel_logic_bench.sv
`timescale 1ns/1ps
module reactor_mode_panel_logic_bench;
    import rmp_pkg::*;

    // ****************************************
    // Signals and model state
    // ****************************************
    // Longer than the worst debounce delay of 2*4+3 cycles
    localparam int SETTLE = 16;
    logic              clock_i;
    logic              sys_rst_i;
    rmp_btn_s          btn;
    rmp_sense_s        sense;
    rmp_sense_s        s_rand;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    rmp_lamps_s        lamps;
    rmp_trips_s        trips;
    logic              warn;
    logic              relay;
    logic              uninterruptible_supply;
    logic [2:0]        door;
    rmp_det_e          det;
    int                mismatches;
    int                checks_done;
    int                m_det;
    int                m_perm;
    int                m_estop;
    int                m_ups;
    int                det_seq[$];
    logic [2:0]        m_ctrl;

    rmp_panel #(
        .DEB_CYC (21'h4),
        .DLY_CYC (33'h28),
        .UPS_CYC (29'hA)
    ) DUT (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .btn_i      (btn),
        .sense_i    (sense),
        .addr_i     (addr),
        .wdata_i    (wdata),
        .wr_i       (wr),
        .rd_i       (rd),
        .rdata_o    (rdata),
        .lamps_o    (lamps),
        .trips_o    (trips),
        .warning_o  (warn),
        .relay_o    (relay),
        .ups_on_o   (uninterruptible_supply),
        .door_cmd_o (door),
        .det_o      (det)
    );

    rmp_console_model CPU (
        .clock_i (clock_i),
        .rdata_i (rdata),
        .addr_o  (addr),
        .wdata_o (wdata),
        .wr_o    (wr),
        .rd_o    (rd)
    );

    // ****************************************
    // Expected values and helpers
    // ****************************************
    function automatic rmp_lamps_s exp_lamps();
        rmp_lamps_s l;
        l = '{region1: sense.lim_r1, region2: !(sense.core_r1 || sense.core_r3),
              region3: sense.lim_r3, door_open: btn.door_open,
              door_stop: btn.door_stop, door_close: btn.door_close,
              operate: (m_perm == 2) && m_ctrl[0], time_delay: m_perm == 1,
              exp_room: sense.exp_room_open, det1: m_det == 1, det2: m_det == 2,
              estop: m_estop != 0, instr_pwr: sense.console_pwr,
              wdt_console: m_ctrl[1], wdt_terminal: m_ctrl[2]};
        if (btn.lamp_test) l = '1;
        return l;
    endfunction : exp_lamps

    function automatic rmp_trips_s exp_trips();
        rmp_trips_s t;
        t = '0;
        if (btn.test1) begin
            case (sense.sel1)
                T1_LOG: {t.log_1kw, t.log_low_src, t.log_period,
                         t.log_hv_lo} = 4'hF;
                T1_MR:   {t.mr_hv_lo, t.mr_pwr_hi} = 2'h3;
                T1_LIN:  {t.lin_hv_lo, t.lin_pwr_hi} = 2'h3;
                default: {t.pul_hv_lo, t.pul_pwr_hi} = 2'h3;
            endcase
        end
        if (btn.test2) begin
            case (sense.sel2)
                T2_WDT:  {t.wdt_console, t.wdt_terminal} = 2'h3;
                T2_LVL:  t.pool_lo = 1'b1;
                T2_FT:   {t.ft1, t.ft2, t.ft3} = 3'h7;
                default: t.pool_temp = 1'b1;
            endcase
        end
        return t;
    endfunction : exp_trips

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask : check

    task automatic check_all();
        check(32'(lamps), 32'(exp_lamps()));
        check(32'(relay), 32'(m_perm == 2));
        check(32'(uninterruptible_supply), 32'(m_ups));
        check(32'(door), {29'h0, btn.door_open, btn.door_stop, btn.door_close});
        check(32'(det), 32'(m_det));
        check(32'(trips), 32'(exp_trips()));
        check(32'(warn), 32'(btn.test1 && sense.sel1 == T1_MR));
    endtask : check_all

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] d;
        CPU.rd_reg(a, d);
        check(d, e);
    endtask : rd_chk

    task automatic settle();
        repeat (SETTLE) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic btn_set(input int b, input logic v);
        @(posedge clock_i);
        btn[b] <= v;
        settle();
    endtask : btn_set

    task automatic end_sim();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        end_sim();
    end

    initial begin
        sys_rst_i = 1'b1;
        btn = '0;
        sense = '0;
        {m_det, m_perm, m_estop, m_ups} = '0;
        m_ctrl = 3'h0;
        det_seq = '{1, 2, 0, 1};
        void'($urandom(32'hB32DCF00));
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        check_all();
        rd_chk(4'h2, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            sense <= rmp_sense_s'($urandom);
            btn[5:1] <= 5'($urandom);
            settle();
            check_all();
            rd_chk(REG_INPUTS, {16'h0, sense.sel2, sense.sel1, btn});
        end
        @(posedge clock_i);
        btn[5:1] <= 5'h0;
        settle();
        check_all();
        $display("test region and door done");
        for (int i = 0; i < 4; i++) begin
            btn_set(B_DET, 1'b1);
            btn_set(B_DET, 1'b0);
            m_det = det_seq.pop_front();
            check_all();
        end
        $display("test detector done");
        btn_set(B_KEY, 1'b1);
        m_perm = 1;
        check_all();
        btn_set(B_KEY, 1'b0);
        check_all();
        settle();
        settle();
        m_perm = 2;
        check_all();
        CPU.wr_reg(REG_CTRL, 32'h1);
        m_ctrl = 3'h1;
        settle();
        check_all();
        rd_chk(REG_CTRL, 32'h1);
        btn_set(B_EST, 1'b1);
        m_estop = 1;
        m_perm = 0;
        check_all();
        btn_set(B_EST, 1'b0);
        btn_set(B_KEY, 1'b1);
        btn_set(B_KEY, 1'b0);
        check_all();
        btn_set(B_EST, 1'b1);
        btn_set(B_EST, 1'b0);
        m_estop = 0;
        check_all();
        $display("test permissive and stop done");
        CPU.wr_reg(REG_CTRL, 32'h6);
        m_ctrl = 3'h6;
        CPU.wr_reg(REG_STATUS, 32'hFFFFFFFF);
        settle();
        check_all();
        rd_chk(REG_CTRL, 32'h6);
        rd_chk(REG_STATUS, {17'h0, exp_lamps()});
        btn_set(B_LT, 1'b1);
        check_all();
        rd_chk(REG_STATUS, 32'h7FFF);
        btn_set(B_LT, 1'b0);
        $display("test watchdog and lamp test done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i);
            btn.instr_pwr <= 1'b1;
            repeat (12) @(posedge clock_i);
            #1;
            check_all();
            btn_set(B_PWR, 1'b0);
            m_ups ^= 1;
            check_all();
        end
        $display("test supply done");
        for (int i = 0; i < 16; i++) begin
            s_rand = rmp_sense_s'($urandom);
            s_rand.sel1 = 2'(i);
            s_rand.sel2 = 2'(i >> 2);
            @(posedge clock_i);
            sense <= s_rand;
            btn[8:7] <= (i < 12) ? 2'(i % 3 + 1) : 2'h3;
            settle();
            check_all();
            rd_chk(REG_TRIPS, {15'h0, exp_trips()});
        end
        btn_set(B_T1, 1'b0);
        btn_set(B_T2, 1'b0);
        check_all();
        $display("test selectors done");
        end_sim();
    end
endmodule : reactor_mode_panel_logic_bench
